// ### logic/bps_sequencer.sv
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "bps_defines.svh"
module bps_sequencer #(
  parameter int TRIP_W = 8
) (
  // Clock and power-on reset
  input wire logic clock,
  input wire logic arst_n,
  // Analog comparators and trip sample
  input wire bps_pkg::bps_sense_t sense_in,
  input wire logic [TRIP_W-1:0] trip_code_in,
  // Register bus
  input wire bps_pkg::bps_ahb_in_t ahb_in,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Power stage control
  output logic high_side_drive,
  output logic low_side_drive,
  output logic trip_source_en,
  output logic [TRIP_W-1:0] held_trip_voltage,
  output logic [5:0] ss_ref_step,
  output logic ref_fixed
);
  import bps_pkg::*;

  localparam logic [6:0] PER_LAST = 7'(`BPS_SW_PERIOD_CYC - 1);
  localparam logic [8:0] SS_LAST = 9'(`BPS_SS_PERIODS - 1);
  localparam logic [2:0] SAMP_LAST = 3'(`BPS_SAMPLE_PERIODS - 1);
  localparam logic [1:0] OC_LAST = 2'(`BPS_OC_LIMIT - 1);
  localparam logic [3:0] DEAD = 4'(`BPS_DEAD_CYC);
  localparam logic [TRIP_W-1:0] TRIP_DEF = TRIP_W'(`BPS_TRIP_DEFAULT_CODE);

  // Step index for a ramp period: floor((period + 1) * 40 / 512)
  function automatic logic [5:0] ramp_step(input logic [8:0] per);
    logic [15:0] prod;
    prod = (16'(per) + 16'h0001) * 16'(`BPS_SS_STEPS);
    return prod[14:9];
  endfunction

  // Comparator synchronisers; first stage feeds only the second
  bps_sense_t sync1_r, s;
  logic [TRIP_W-1:0] trip1_r, trip_s;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= '0;
      s <= '0;
      trip1_r <= '0;
      trip_s <= '0;
    end else begin
      sync1_r <= sense_in;
      s <= sync1_r;
      trip1_r <= trip_code_in;
      trip_s <= trip1_r;
    end
  end

  // Switching oscillator derived from the system clock
  logic [6:0] prescale_r;
  logic sw_tick;
  assign sw_tick = (prescale_r == PER_LAST);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prescale_r <= '0;
    end else begin
      prescale_r <= sw_tick ? 7'h00 : prescale_r + 7'h01;
    end
  end

  bps_state_t state_r, state_nxt;
  logic [8:0] ramp_per_r;
  logic [2:0] samp_cnt_r;
  logic [1:0] oc_cnt_r;
  logic hs_r, ls_r;
  logic skip_en_r;
  logic oc_event, uv_event, running;

  assign running = (state_r == BPS_RAMP) || (state_r == BPS_RUN);
  assign oc_event = running && ls_r && s.oc_trip;
  assign uv_event = (state_r == BPS_RUN) && s.fb_under;

  always_comb begin
    state_nxt = state_r;
    if (!s.supply_ok || !s.comp_enable) begin
      state_nxt = BPS_OFF;
    end else begin
      case (state_r)
        BPS_OFF: state_nxt = BPS_SAMPLE;
        BPS_SAMPLE: begin
          if (sw_tick && samp_cnt_r == SAMP_LAST) begin
            state_nxt = BPS_RAMP;
          end
        end
        BPS_RAMP: begin
          if (oc_event) begin
            state_nxt = (oc_cnt_r == OC_LAST) ? BPS_FAULT : BPS_SAMPLE;
          end else if (sw_tick && ramp_per_r == SS_LAST) begin
            state_nxt = BPS_RUN;
          end
        end
        BPS_RUN: begin
          if (uv_event) begin
            state_nxt = BPS_FAULT;
          end else if (oc_event) begin
            state_nxt = (oc_cnt_r == OC_LAST) ? BPS_FAULT : BPS_SAMPLE;
          end
        end
        BPS_FAULT: state_nxt = BPS_FAULT;
        default: state_nxt = BPS_OFF;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= BPS_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Event count survives restarts, cleared only through the off state
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      oc_cnt_r <= '0;
    end else if (state_nxt == BPS_OFF) begin
      oc_cnt_r <= '0;
    end else if (oc_event && oc_cnt_r != OC_LAST + 2'h1) begin
      oc_cnt_r <= oc_cnt_r + 2'h1;
    end
  end

  // Trip sampling window and ramp period counter
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      samp_cnt_r <= '0;
      ramp_per_r <= '0;
    end else begin
      samp_cnt_r <= (state_r != BPS_SAMPLE) ? 3'h0 : samp_cnt_r + 3'(sw_tick);
      ramp_per_r <= (state_r != BPS_RAMP) ? 9'h000 : ramp_per_r + 9'(sw_tick);
    end
  end

  // Current source runs only in the sampling window; the sample is held after
  // because the pin becomes a gate drive again once switching starts.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      trip_source_en <= 1'b0;
      held_trip_voltage <= TRIP_DEF;
    end else begin
      trip_source_en <= (state_nxt == BPS_SAMPLE);
      if (state_r == BPS_SAMPLE && state_nxt == BPS_RAMP) begin
        held_trip_voltage <= (trip_s > TRIP_DEF) ? TRIP_DEF : trip_s;
      end
    end
  end

  // Stepped reference, then the fixed one
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ss_ref_step <= '0;
      ref_fixed <= 1'b0;
    end else begin
      ref_fixed <= (state_nxt == BPS_RUN);
      if (state_nxt == BPS_RUN) begin
        ss_ref_step <= 6'(`BPS_SS_STEPS);
      end else if (state_r == BPS_RAMP) begin
        ss_ref_step <= ramp_step(ramp_per_r);
      end else begin
        ss_ref_step <= '0;
      end
    end
  end

  // Cycle-based reversal and skip flags; a new reversal beats the cycle clear
  logic rev_r, skip_cycle_r;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rev_r <= 1'b0;
      skip_cycle_r <= 1'b0;
    end else begin
      if (ls_r && s.current_reversal_comparator) begin
        rev_r <= 1'b1;
      end else if (sw_tick) begin
        rev_r <= 1'b0;
      end
      if (sw_tick) begin
        skip_cycle_r <= skip_en_r && s.skip_req && (state_r == BPS_RUN);
      end
    end
  end

  logic hs_want, ls_want;
  assign hs_want = running && s.pwm_on && !skip_cycle_r && !s.fb_over;
  assign ls_want = running && (s.fb_over || (!s.pwm_on && !rev_r));

  // Dead-time counters start once the opposite gate is seen low
  logic [3:0] lo_off_cnt_r, hi_off_cnt_r;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lo_off_cnt_r <= '0;
      hi_off_cnt_r <= '0;
    end else begin
      if (ls_r || !s.low_side_drive_low) begin
        lo_off_cnt_r <= '0;
      end else if (lo_off_cnt_r != DEAD) begin
        lo_off_cnt_r <= lo_off_cnt_r + 4'h1;
      end
      if (hs_r || !s.hgate_low) begin
        hi_off_cnt_r <= '0;
      end else if (hi_off_cnt_r != DEAD) begin
        hi_off_cnt_r <= hi_off_cnt_r + 4'h1;
      end
    end
  end

  // A drive may stay on while wanted; turning on needs the other side off
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hs_r <= 1'b0;
      ls_r <= 1'b0;
    end else begin
      hs_r <= hs_want && !ls_r && (hs_r || lo_off_cnt_r == DEAD);
      ls_r <= ls_want && !hs_r && (ls_r || hi_off_cnt_r == DEAD);
    end
  end
  assign high_side_drive = hs_r;
  assign low_side_drive = ls_r;

  // AHB-Lite slave: zero wait states, always OKAY
  logic wr_pend_r;
  logic [31:0] wr_addr_r;
  logic addr_valid;
  assign addr_valid = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;

  function automatic logic [31:0] read_word(input logic [31:0] addr);
    case (addr)
      `BPS_REG_CTRL: read_word = {31'h0, skip_en_r};
      `BPS_REG_STATUS: read_word = {18'h0, ss_ref_step, ref_fixed, ls_r, hs_r,
                                    oc_cnt_r, state_r};
      `BPS_REG_TRIP: read_word = 32'(held_trip_voltage);
      default: read_word = 32'h0000_0000;
    endcase
  endfunction

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (ahb_in.hready) begin
        wr_pend_r <= addr_valid && ahb_in.hwrite;
        wr_addr_r <= ahb_in.haddr;
        if (addr_valid && !ahb_in.hwrite) begin
          hrdata <= read_word(ahb_in.haddr);
        end
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      skip_en_r <= 1'(`BPS_CTRL_RESET);
    end else if (wr_pend_r && wr_addr_r == `BPS_REG_CTRL) begin
      skip_en_r <= ahb_in.hwdata[`BPS_CTRL_SKIP_BIT];
    end
  end

  // Checks
  no_overlap_a: assert property (@(posedge clock) disable iff (!arst_n)
    !(hs_r && ls_r)) else $error("both gate drives on");
  hs_dead_a: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(hs_r) |-> $past(lo_off_cnt_r) == DEAD && $past(s.low_side_drive_low))
    else $error("high-side rose without low-side dead time");
  ls_dead_a: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(ls_r) |-> $past(hi_off_cnt_r) == DEAD && $past(s.hgate_low))
    else $error("low-side rose without high-side dead time");
  supply_inhibit_a: assert property (@(posedge clock) disable iff (!arst_n)
    !s.supply_ok |=> state_r == BPS_OFF ##1 (!hs_r && !ls_r))
    else $error("drives not off with supply low");
  comp_shutdown_a: assert property (@(posedge clock) disable iff (!arst_n)
    !s.comp_enable [*3] |-> !hs_r && !ls_r && state_r == BPS_OFF)
    else $error("drives active while disabled");
  run_ref_a: assert property (@(posedge clock) disable iff (!arst_n)
    state_r == BPS_RUN |-> ref_fixed && ss_ref_step == 6'(`BPS_SS_STEPS))
    else $error("fixed reference not selected in run");
  trip_window_a: assert property (@(posedge clock) disable iff (!arst_n)
    trip_source_en == (state_r == BPS_SAMPLE))
    else $error("trip source outside sampling window");
  trip_clamp_a: assert property (@(posedge clock) disable iff (!arst_n)
    held_trip_voltage <= TRIP_DEF) else $error("held trip above default");
  oc_latch_a: assert property (@(posedge clock) disable iff (!arst_n)
    (oc_event && oc_cnt_r == OC_LAST && s.supply_ok && s.comp_enable)
    |=> state_r == BPS_FAULT ##1 (!hs_r && !ls_r))
    else $error("second over-current did not latch");
  uv_latch_a: assert property (@(posedge clock) disable iff (!arst_n)
    (uv_event && s.supply_ok && s.comp_enable)
    |=> state_r == BPS_FAULT ##1 (!hs_r && !ls_r))
    else $error("under-voltage did not latch");
  fault_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    (state_r == BPS_FAULT && s.supply_ok && s.comp_enable) |=> state_r == BPS_FAULT)
    else $error("fault left without disable or power cycle");
  ovp_clamp_a: assert property (@(posedge clock) disable iff (!arst_n)
    (s.fb_over && running) [*2] |-> !hs_r)
    else $error("high-side on during over-voltage");
endmodule

// ### logic/bps_defines.svh
`ifndef BPS_DEFINES_SVH
`define BPS_DEFINES_SVH
`define BPS_CLK_HZ 25000000
`define BPS_CLK_MHZ 25
`define BPS_SW_HZ 300000
`define BPS_SW_PERIOD_CYC (`BPS_CLK_HZ / `BPS_SW_HZ)
`define BPS_SS_STEPS 40
`define BPS_SS_PERIODS 512
`define BPS_SAMPLE_PERIODS 4
`define BPS_OC_LIMIT 2
`define BPS_DEAD_NS 80
`define BPS_DEAD_CYC ((`BPS_DEAD_NS * `BPS_CLK_MHZ + 999) / 1000)
`define BPS_TRIP_LSB_MV 5
`define BPS_TRIP_DEFAULT_MV 300
`define BPS_TRIP_DEFAULT_CODE (`BPS_TRIP_DEFAULT_MV / `BPS_TRIP_LSB_MV)
`define BPS_REG_CTRL 32'h0000_0000
`define BPS_REG_STATUS 32'h0000_0004
`define BPS_REG_TRIP 32'h0000_0008
`define BPS_CTRL_SKIP_BIT 0
`define BPS_CTRL_RESET 32'h0000_0001
`endif

// ### logic/bps_pkg.sv
package bps_pkg;
  // Gray codes along off, sample, ramp, run, fault
  typedef enum logic [2:0] {
    BPS_OFF    = 3'h0,
    BPS_SAMPLE = 3'h1,
    BPS_RAMP   = 3'h3,
    BPS_RUN    = 3'h2,
    BPS_FAULT  = 3'h6
  } bps_state_t;

  // Comparator levels arriving from the analog side
  typedef struct packed {
    logic supply_ok;
    logic comp_enable;
    logic fb_under;
    logic fb_over;
    logic oc_trip;
    logic current_reversal_comparator;
    logic low_side_drive_low;
    logic hgate_low;
    logic pwm_on;
    logic skip_req;
  } bps_sense_t;

  // AHB-Lite slave inputs
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } bps_ahb_in_t;
endpackage

// ### tb/bps_power_stage.sv
`timescale 1ns/1ps
module bps_power_stage #(
  parameter logic [7:0] TRIP_CODE = 8'h46
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Gate commands and trip source
  input wire logic high_side_drive,
  input wire logic low_side_drive,
  input wire logic trip_source_en,
  // Sensed levels
  output logic low_side_drive_low,
  output logic hgate_low,
  output logic [7:0] trip_code
);
  // Gates discharge a cycle after the command drops, so a careless interlock overlaps
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      low_side_drive_low <= 1'b1;
      hgate_low <= 1'b1;
    end else begin
      low_side_drive_low <= !low_side_drive;
      hgate_low <= !high_side_drive;
    end
  end
  // Without the source the node floats; a moving code exposes a stale sample
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      trip_code <= 8'h00;
    end else begin
      trip_code <= trip_source_en ? TRIP_CODE : trip_code + 8'h35;
    end
  end
endmodule

// ### tb/test_buck_protection_sequencer.sv
`timescale 1ns/1ps
`include "bps_defines.svh"
module test_buck_protection_sequencer;
  import bps_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  bps_ahb_in_t bus = '0;
  bps_sense_t drv = '0;
  bps_ahb_in_t ahb_in;
  bps_sense_t sense_in;
  logic [31:0] hrdata;
  logic hreadyout, hresp, high_side_drive, low_side_drive, trip_source_en, ref_fixed;
  logic lgl, hgl, hs_prev, ls_prev;
  logic [7:0] trip_code, held_trip_voltage;
  logic [5:0] ss_ref_step;
  logic [31:0] rd;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int lo_off = 0;
  int hi_off = 0;

  always #20 clock = ~clock;
  assign ahb_in = {bus.hsel, bus.haddr, bus.htrans, bus.hwrite, bus.hsize, bus.hwdata, hreadyout};
  assign sense_in = {drv.supply_ok, drv.comp_enable, drv.fb_under, drv.fb_over, drv.oc_trip,
    drv.current_reversal_comparator, lgl, hgl, drv.pwm_on, drv.skip_req};

  bps_sequencer i_dut (.clock(clock), .arst_n(arst_n), .sense_in(sense_in),
    .trip_code_in(trip_code), .ahb_in(ahb_in), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
    .trip_source_en(trip_source_en), .held_trip_voltage(held_trip_voltage),
    .ss_ref_step(ss_ref_step), .ref_fixed(ref_fixed));
  bps_power_stage i_stage (.clock(clock), .arst_n(arst_n), .high_side_drive(high_side_drive),
    .low_side_drive(low_side_drive), .trip_source_en(trip_source_en), .low_side_drive_low(lgl),
    .hgate_low(hgl), .trip_code(trip_code));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Entered right after a rising edge; the bench timeout ends a hung wait
  task automatic bus_op(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
    bus.hsel <= 1'b1;
    bus.haddr <= addr;
    bus.htrans <= 2'h2;
    bus.hwrite <= wr;
    bus.hsize <= 3'h2;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    bus.hsel <= 1'b0;
    bus.htrans <= 2'h0;
    bus.hwdata <= wdata;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask

  task automatic wait_src(input logic lvl, input int lim);
    int i;
    i = 0;
    while (trip_source_en !== lvl && i < lim) begin
      @(posedge clock);
      i++;
    end
  endtask

  // Interlock watch over the whole run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      print_verdict();
    end
    if (arst_n) begin
      if (high_side_drive === 1'b1 && low_side_drive === 1'b1) check(1, 0);
      if (high_side_drive === 1'b1 && hs_prev === 1'b0) check(lo_off >= 3, 1);
      if (low_side_drive === 1'b1 && ls_prev === 1'b0) check(hi_off >= 3, 1);
    end
    hs_prev = high_side_drive;
    ls_prev = low_side_drive;
    lo_off = (low_side_drive === 1'b0) ? lo_off + 1 : 0;
    hi_off = (high_side_drive === 1'b0) ? hi_off + 1 : 0;
  end

  task automatic t_regs();
    check({hreadyout, hresp, high_side_drive, low_side_drive, ref_fixed}, 5'h10);
    check(held_trip_voltage, `BPS_TRIP_DEFAULT_CODE);
    bus_op(1'b0, `BPS_REG_CTRL, 32'h0);
    check(rd, `BPS_CTRL_RESET);
    bus_op(1'b1, `BPS_REG_CTRL, 32'h0);
    bus_op(1'b0, `BPS_REG_CTRL, 32'h0);
    check(rd, 32'h0);
    bus_op(1'b1, `BPS_REG_CTRL, 32'h1);
    bus_op(1'b1, `BPS_REG_TRIP, 32'h5);
    bus_op(1'b0, `BPS_REG_TRIP, 32'h0);
    check(rd, `BPS_TRIP_DEFAULT_CODE);
    bus_op(1'b0, 32'h0000_0040, 32'h0);
    check(rd, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_startup();
    int n;
    drv.comp_enable <= 1'b1;
    drv.pwm_on <= 1'b1;
    cyc(200);
    check({high_side_drive, low_side_drive, trip_source_en}, 3'h0);
    drv.supply_ok <= 1'b1;
    wait_src(1'b1, 10);
    check(trip_source_en, 1'b1);
    wait_src(1'b0, 500);
    check(held_trip_voltage, `BPS_TRIP_DEFAULT_CODE);
    n = 0;
    while (ref_fixed !== 1'b1 && n < 45000) begin
      @(posedge clock);
      n++;
      if (n == 21248) check(ss_ref_step >= 6'd19 && ss_ref_step <= 6'd21, 1);
    end
    check(n >= 42413 && n <= 42579, 1);
    check(ss_ref_step, `BPS_SS_STEPS);
    check(ref_fixed, 1'b1);
    $display("test startup done");
  endtask

  task automatic t_run();
    drv.skip_req <= 1'b1;
    cyc(200);
    check(high_side_drive, 1'b0);
    drv.skip_req <= 1'b0;
    cyc(200);
    check(high_side_drive, 1'b1);
    repeat (8) begin
      drv.pwm_on <= ~drv.pwm_on;
      cyc(20);
    end
    drv.fb_over <= 1'b1;
    cyc(20);
    check({high_side_drive, low_side_drive}, 2'h1);
    drv.fb_over <= 1'b0;
    cyc(20);
    check({high_side_drive, low_side_drive}, 2'h2);
    drv.pwm_on <= 1'b0;
    cyc(20);
    drv.current_reversal_comparator <= 1'b1;
    cyc(6);
    check(low_side_drive, 1'b0);
    drv.current_reversal_comparator <= 1'b0;
    cyc(100);
    drv.fb_under <= 1'b1;
    cyc(6);
    check({high_side_drive, low_side_drive}, 2'h0);
    drv.fb_under <= 1'b0;
    cyc(20);
    bus_op(1'b0, `BPS_REG_STATUS, 32'h0);
    check(rd[2:0], 3'h6);
    drv.comp_enable <= 1'b0;
    cyc(10);
    check({high_side_drive, low_side_drive}, 2'h0);
    drv.comp_enable <= 1'b1;
    wait_src(1'b1, 10);
    check(trip_source_en, 1'b1);
    wait_src(1'b0, 500);
    $display("test run done");
  endtask

  task automatic t_fault();
    cyc(200);
    drv.oc_trip <= 1'b1;
    cyc(8);
    drv.oc_trip <= 1'b0;
    bus_op(1'b0, `BPS_REG_STATUS, 32'h0);
    check(rd[4:0], 5'h09);
    wait_src(1'b0, 500);
    cyc(300);
    drv.oc_trip <= 1'b1;
    cyc(8);
    drv.oc_trip <= 1'b0;
    cyc(100);
    bus_op(1'b0, `BPS_REG_STATUS, 32'h0);
    check(rd[2:0], 3'h6);
    check({high_side_drive, low_side_drive}, 2'h0);
    drv.comp_enable <= 1'b0;
    cyc(10);
    bus_op(1'b0, `BPS_REG_STATUS, 32'h0);
    check(rd[6:0], 7'h00);
    drv.comp_enable <= 1'b1;
    wait_src(1'b1, 10);
    check(trip_source_en, 1'b1);
    $display("test fault done");
  endtask

  initial begin
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    t_regs();
    t_startup();
    t_run();
    t_fault();
    print_verdict();
  end
endmodule
